//--- tb/scf_front_end_assertions.sv
// Purpose: Port checks for the serial command front end
// Assumes: One sys_clk_i domain, reset_i async active high
// Notes: Bound to every scf_front_end instance
`timescale 1ns/1ps
module scf_front_end_assertions (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic conv_start_n_i,
    input wire logic conv_done_i,
    input wire logic eoc_n_o,
    input wire logic [7:0] conversion_control_o,
    input wire logic [7:0] setup_config_o,
    input wire logic [7:0] averaging_control_o,
    input wire logic [15:0] dac_word_o,
    input wire logic dac_word_stb_o,
    input wire logic gpio_stb_o,
    input wire logic conv_req_o,
    input wire logic conv_single_o,
    input wire logic [11:0] dac_input_o
);
    // ==========================================================
    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    wire logic [1:0] ck = setup_config_o[5:4];
    sequence quiet_s; cs_n_i [*8]; endsequence
    sequence start_fall_s; $fell(conv_start_n_i) && cs_n_i; endsequence
    a_regs_hold_idle: assert property (quiet_s |-> $stable(conversion_control_o) && $stable(setup_config_o)
        && $stable(averaging_control_o)) else $error("register changed with chip select high");
    a_eoc_cs_fall: assert property ($fell(cs_n_i) |-> ##[1:6] eoc_n_o)
        else $error("end flag not raised after select fall");
    a_eoc_start_fall: assert property (start_fall_s |-> ##[1:6] eoc_n_o)
        else $error("end flag not raised after start fall");
    a_eoc_mode11_high: assert property (ck == 2'b11 && $past(ck) == 2'b11 |-> eoc_n_o)
        else $error("end flag low in mode 11");
    a_eoc_done_low: assert property (conv_done_i && cs_n_i && conv_start_n_i && ck != 2'b11 |-> ##[1:3] !eoc_n_o)
        else $error("end flag not lowered after done");
    a_dac_stb_pulse: assert property (dac_word_stb_o |=> !dac_word_stb_o)
        else $error("dac strobe longer than one cycle");
    a_gpio_stb_pulse: assert property (gpio_stb_o |=> !gpio_stb_o)
        else $error("gpio strobe longer than one cycle");
    a_req_one_cycle: assert property (conv_req_o |=> !conv_req_o)
        else $error("request longer than one cycle");
    a_dac_input_load: assert property (dac_word_stb_o |-> ##[0:2] dac_input_o == dac_word_o[11:0])
        else $error("dac input not loaded from word");
    a_mode00_start: assert property (start_fall_s ##0 ck == 2'b00 |-> ##[1:6] conv_req_o)
        else $error("start pin gave no request in mode 00");
    a_mode01_single: assert property (conv_req_o && ck == 2'b01 |-> conv_single_o)
        else $error("mode 01 request not single");
endmodule
bind scf_front_end scf_front_end_assertions scf_front_end_assertions_inst (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .cs_n_i(cs_n_i), .conv_start_n_i(conv_start_n_i), .conv_done_i(conv_done_i),
    .eoc_n_o(eoc_n_o), .conversion_control_o(conversion_control_o), .setup_config_o(setup_config_o),
    .averaging_control_o(averaging_control_o), .dac_word_o(dac_word_o), .dac_word_stb_o(dac_word_stb_o),
    .gpio_stb_o(gpio_stb_o), .conv_req_o(conv_req_o), .conv_single_o(conv_single_o),
    .dac_input_o(dac_input_o));

//--- tb/scf_front_end_test.sv
// Purpose: Self-checking bench for the serial command front end
// Assumes: 50 MHz clock, master model with a 160 ns link clock, 240 ns in clock mode 11
// Notes: Command-byte registers take effect after eight bits; data bytes need the full frame
`timescale 1ns/1ps
module scf_front_end_test;
    import scf_pkg::*;
    logic sys_clk_i, reset_i, cs_n, sclk, din, start_n, lvl, done, rbip, rval, dout, eoc_n;
    logic dstb, gstb, req, single;
    logic [7:0] conv, setup, avg, rstc, uni, bip, m_conv, m_setup, m_avg, m_uni, m_bip;
    logic [1:0] gpc;
    logic [15:0] dacw, gpw, result, m_dacw;
    logic [11:0] dacin, m_dacin;
    logic [31:0] r;
    int fail_count, checks, nreq, ndac, ngp, nsgl, m_req, m_dac, m_gp;
    scf_spi_master master_inst (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
    scf_front_end scf_front_end_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .conv_start_n_i(start_n), .dac_powerup_level_i(lvl), .conv_done_i(done),
        .result_bipolar_i(rbip), .result_valid_i(rval), .dout_o(dout), .eoc_n_o(eoc_n),
        .conversion_control_o(conv), .setup_config_o(setup), .averaging_control_o(avg), .reset_control_o(rstc),
        .unipolar_mode_o(uni), .bipolar_mode_o(bip), .dac_word_o(dacw), .dac_word_stb_o(dstb),
        .gpio_word_o(gpw), .gpio_cmd_o(gpc), .gpio_stb_o(gstb), .conv_req_o(req), .conv_single_o(single),
        .dac_input_o(dacin), .result_o(result));
    // ==========================================================
    // Clock, monitor, helpers
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        nreq += (req === 1'b1);
        nsgl += (req === 1'b1 && single === 1'b1);
        ndac += (dstb === 1'b1);
        ngp += (gstb === 1'b1);
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        if (fail_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic do_reset(input logic l);
        lvl = l;
        reset_i = 1'b1;
        repeat (5) @(negedge sys_clk_i);
        reset_i = 1'b0;
        {m_conv, m_avg, m_uni, m_bip, m_dacw} = '0;
        m_setup = 8'h28;
        m_dacin = {12{l}};
        master_inst.half = 80;
        repeat (4) @(negedge sys_clk_i);
    endtask
    task automatic check_all;
        chk(conv, m_conv);
        chk(setup, m_setup);
        chk(avg, m_avg);
        chk(uni, m_uni);
        chk(bip, m_bip);
        chk(dacw, m_dacw);
        chk(dacin, m_dacin);
        chk(16'(nreq), 16'(m_req));
        chk(16'(ndac), 16'(m_dac));
        chk(result, 16'h0000);
        chk({15'h0, dout}, 16'h0000);
    endtask
    // Model: a whole command byte writes its register; data bytes need the full frame
    task automatic send(input logic [23:0] d, input int n);
        logic [7:0] c;
        int need;
        c = d[23:16];
        need = (c[7:4] == 4'h1 || (c[7:2] == 6'h0 && c[1:0] != 2'b00)) ? 24 : (c[7:6] == 2'b01 && c[1]) ? 16 : 8;
        master_inst.frame(d, n, 1'($urandom % 2));
        repeat (4) @(negedge sys_clk_i);
        if (n >= 8) begin
            if (c[7]) begin
                m_conv = c;
                m_req += m_setup[5];
            end else if (c[6]) begin
                m_setup = c;
                if (n >= need && c[1:0] == 2'b10) m_uni = d[15:8];
                if (n >= need && c[1:0] == 2'b11) m_bip = d[15:8];
                master_inst.half = (c[5:4] == 2'b11) ? 120 : 80;
            end else if (c[5]) m_avg = c;
            else if (c[4] && n >= need) begin
                m_dacw = d[15:0];
                m_dacin = d[11:0];
                m_dac++;
            end else if (c[3] && c[2]) begin
                {m_conv, m_avg} = '0;
                m_setup = 8'h28;
            end
        end
    endtask
    task automatic hit(input logic s);
        {start_n, done} = s ? 2'b01 : 2'b11;
        repeat (3) @(negedge sys_clk_i);
        {start_n, done} = 2'b10;
        repeat (8) @(negedge sys_clk_i);
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        {fail_count, checks, nreq, ndac, ngp, nsgl, m_req, m_dac, m_gp} = '0;
        {start_n, done, rbip, rval} = 4'b1000;
        void'($urandom(14414));
        do_reset(1'b1);
        check_all;
        chk(rstc, 8'h00);
        for (int i = 0; i < 4; i++) begin
            r = $urandom;
            send({1'b1, r[6:0], r[15:0]}, 8 + 8 * (i % 2));
            send({3'b001, r[20:16], 16'h0000}, 8);
            send(24'h00_0000, 8);
            send({4'h6, 2'(r[25:24]), 2'(i), r[15:0]}, 16);
            check_all;
        end
        send({8'h6A, r[15:0]}, 12);
        send({1'b1, r[30:24], 16'h0000}, 8);
        check_all;
        for (int i = 0; i < 2; i++) begin
            r = $urandom;
            send({4'h1, r[19:0]}, 24);
            check_all;
        end
        for (int c = 1; c < 4; c++) begin
            r = $urandom;
            m_gp = ngp;
            send({8'(c), r[15:0]}, 24);
            chk(gpw, r[15:0]);
            chk({14'h0, gpc}, 16'(c));
            chk(16'(ngp), 16'(m_gp + 1));
        end
        send(24'h0B_0000, 8);
        chk(rstc[2:0], 3'b011);
        send(24'h0C_0000, 8);
        check_all;
        rval = 1'b1;
        hit(1'b0);
        rval = 1'b0;
        chk(eoc_n, 1'b0);
        send(24'h00_0000, 8);
        chk(eoc_n, 1'b1);
        send(24'h40_0000, 8);
        hit(1'b0);
        chk(eoc_n, 1'b0);
        hit(1'b1);
        chk(eoc_n, 1'b1);
        chk(16'(nreq), 16'(m_req + 1));
        send(24'h50_0000, 8);
        m_req = nreq;
        hit(1'b1);
        chk(16'(nreq), 16'(m_req + 1));
        chk(16'(nsgl), 16'h0001);
        m_req = nreq;
        send(24'h70_0000, 8);
        hit(1'b0);
        chk(eoc_n, 1'b1);
        send(24'h80_0000, 8);
        chk(16'(nsgl), 16'h0002);
        chk(eoc_n, 1'b1);
        check_all;
        do_reset(1'b0);
        check_all;
        results;
    end
    initial begin
        #1_000_000;
        fail_count++;
        results;
    end
endmodule

//--- tb/scf_spi_master.sv
// Purpose: Bus master model driving the serial pins
// Assumes: Link clock of 160 ns unless half is changed (240 ns with half at 120), every pin edge falling on a sys_clk_i falling edge
// Notes: SCLK stands still between frames; DIN shows the inverse of its last bit when idle
`timescale 1ns/1ps
module scf_spi_master (
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o
);
    // ==========================================================
    // Frame driver
    int half = 80;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        din_o = 1'b0;
    end
    // Idle level picks mode 0 or 3, polarity equal to phase
    // DIN moves only while SCLK is high, so it is settled half a period around each fall
    task automatic frame(input logic [23:0] d, input int n, input logic mode3);
        sclk_o = mode3;
        #(half) cs_n_o = 1'b0;
        for (int i = 23; i > 23 - n; i--) begin
            if (mode3) din_o = d[i];
            #(half) sclk_o = ~sclk_o;
            if (!mode3) din_o = d[i];
            #(half) sclk_o = ~sclk_o;
        end
        #(half) cs_n_o = 1'b1;
        din_o = ~din_o;
        #200;
    endtask
endmodule

//--- verilog/scf_front_end.sv
// Purpose: Serial command front end: decode, register writes, conversion requests
// Assumes: Serial pins oversampled by sys_clk_i (50 MHz); SCLK below about 12 MHz here
// Notes: Oversampling limits the usable serial clock; analog side is outside
`timescale 1ns/1ps

// Behaviour
// [R1] Master keeps SCLK at most 25MHz, CPOL equals CPHA; modes 0 and 3 both work; here the oversampling needs SCLK below about 12 MHz.
// [R2] With chip select low, data in is sampled on each SCLK falling edge.
// [R3] Clock modes 00, 01, 10 change data out on SCLK falling edge.
// [R4] Clock mode 11 changes data out on SCLK rising edge.
// [R5] Bipolar differential and temperature results two's complement, others straight binary; here result_bipolar_i changes nothing in result_o.
// [R6] First eight bits after chip select falls are the command, MSB first.
// [R7] Command decides frame length 8, 16 or 24 bits and target section.
// [R8] Chip select high returns interface to idle, next frame starts with command.
// [R9] Command decoded by highest set bit; 03h,02h,01h are GPIO; zero is no-op.
// [R10] Setup bits 5:4 clock mode, 3:2 reference mode, 1:0 polarity register select.
// [R11] Polarity register load needs a second byte after setup, chip select held low.
// [R12] DAC command 0001XXXX followed by two bytes carrying selection and data.
// [R13] GPIO commands take one data byte (four GPIO) or two (twelve GPIO).
// [R14] Without GPIO, GPIO commands are ignored and change no state.
// [R15] Power-up: blocks shut down, registers zero, setup register 28h.
// [R16] DAC input register powers up FFFh with level select high, else 000h.
// [R17] Clock mode 00: conversion-start low requests internally timed conversions.
// [R18] Clock mode 01: each conversion-start request converts one channel.
// [R19] Clock mode 10: conversion register write starts internally timed conversions.
// [R20] Clock mode 11: SCLK at most 4.8MHz; scanning and averaging disabled; here only conv_single_o is forced, averaging is left as written.
// [R21] End-of-conversion low when done; high on CS or start fall; high in mode 11.
// [R22] Bytes after command are data; bits beyond decoded frame length ignored.
module scf_front_end
    import scf_pkg::*;
#(
    parameter int GPIO_COUNT = 12
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic conv_start_n_i,
    input wire logic dac_powerup_level_i,
    input wire logic conv_done_i,
    input wire logic result_bipolar_i,
    input wire logic result_valid_i,
    output logic dout_o,
    output logic eoc_n_o,
    output logic [7:0] conversion_control_o,
    output logic [7:0] setup_config_o,
    output logic [7:0] averaging_control_o,
    output logic [7:0] reset_control_o,
    output logic [7:0] unipolar_mode_o,
    output logic [7:0] bipolar_mode_o,
    output logic [15:0] dac_word_o,
    output logic dac_word_stb_o,
    output logic [15:0] gpio_word_o,
    output logic [1:0] gpio_cmd_o,
    output logic gpio_stb_o,
    output logic conv_req_o,
    output logic conv_single_o,
    output logic [11:0] dac_input_o,
    output logic [15:0] result_o
);
    // ==========================================================
    // Pin synchronisers
    logic cs_n_s, sclk_s, din_s, cnv_n_s;
    scf_sync #(.RESET_VAL(1'b1)) u_cs (.clk_i(sys_clk_i), .reset_i(reset_i), .d_i(cs_n_i), .q_o(cs_n_s));
    scf_sync #(.RESET_VAL(1'b0)) u_ck (.clk_i(sys_clk_i), .reset_i(reset_i), .d_i(sclk_i), .q_o(sclk_s));
    scf_sync #(.RESET_VAL(1'b0)) u_di (.clk_i(sys_clk_i), .reset_i(reset_i), .d_i(din_i), .q_o(din_s));
    scf_sync #(.RESET_VAL(1'b1)) u_cv (.clk_i(sys_clk_i), .reset_i(reset_i), .d_i(conv_start_n_i), .q_o(cnv_n_s));

    logic sclk_d_r, cs_n_d_r, cnv_n_d_r;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
            cnv_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
            cnv_n_d_r <= cnv_n_s;
        end
    end

    // Both SPI modes 0 and 3 sample on the same falling edge, so idle level needs no tracking
    wire sclk_fall = sclk_d_r & ~sclk_s & ~cs_n_s; // [R1] [R2]
    wire sclk_rise = ~sclk_d_r & sclk_s & ~cs_n_s;
    wire cs_fall = cs_n_d_r & ~cs_n_s;
    wire cnv_fall = cnv_n_d_r & ~cnv_n_s;

    // ==========================================================
    // Command decode
    function automatic scf_cmd_s decode_cmd(input logic [7:0] c);
        scf_cmd_s d;
        d = '{target: SCF_TGT_NONE, data_bytes: BYTES_0, kind: K_NOP};
        if (c[CONV_BIT]) begin // [R9]
            d = '{target: SCF_TGT_ADC, data_bytes: BYTES_0, kind: K_CONV};
        end else if (c[SETUP_BIT]) begin
            d = '{target: SCF_TGT_ADC, data_bytes: (c[POL_HI:POL_LO] != 2'b00) ? BYTES_1 : BYTES_0,
                  kind: K_SETUP}; // [R11]
        end else if (c[AVG_BIT]) begin
            d = '{target: SCF_TGT_ADC, data_bytes: BYTES_0, kind: K_AVG};
        end else if (c[DAC_BIT]) begin
            d = '{target: SCF_TGT_DAC, data_bytes: BYTES_2, kind: K_DAC}; // [R12]
        end else if (c[RST_BIT]) begin
            d = '{target: SCF_TGT_ADC, data_bytes: BYTES_0, kind: K_RST};
        end else if (GPIO_COUNT != 0 && (c == CMD_GPIO_CFG || c == CMD_GPIO_WR || c == CMD_GPIO_RD)) begin
            d = '{target: SCF_TGT_GPIO, data_bytes: (GPIO_COUNT > 4) ? BYTES_2 : BYTES_1,
                  kind: (c == CMD_GPIO_RD) ? K_GPIO_RD : K_GPIO}; // [R13] [R14]
        end
        return d; // [R7]
    endfunction

    // ==========================================================
    // Shift and frame sequencing
    scf_state_e state_r;
    logic [2:0] bit_cnt_r;
    logic [1:0] byte_left_r;
    logic [7:0] shift_r;
    logic [7:0] cmd_r;
    logic [15:0] data_r;
    scf_cmd_s dec_r;
    wire [7:0] byte_nxt = {shift_r[6:0], din_s};
    wire byte_done = sclk_fall && bit_cnt_r == BIT_LAST;
    scf_cmd_s dec_now;
    assign dec_now = decode_cmd(byte_nxt);

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_r <= SCF_ST_CMD;
            bit_cnt_r <= '0;
            byte_left_r <= BYTES_0;
            shift_r <= REG_CLEAR;
            cmd_r <= REG_CLEAR;
            dec_r <= '0;
            data_r <= '0;
        end else if (cs_n_s) begin
            state_r <= SCF_ST_CMD; // [R8]
            bit_cnt_r <= '0;
            byte_left_r <= BYTES_0;
        end else if (sclk_fall) begin
            shift_r <= byte_nxt; // [R6]
            bit_cnt_r <= bit_cnt_r + 3'd1;
            if (byte_done) begin
                case (state_r)
                    SCF_ST_CMD: begin
                        cmd_r <= byte_nxt;
                        dec_r <= dec_now;
                        byte_left_r <= dec_now.data_bytes;
                        state_r <= (dec_now.data_bytes == BYTES_0) ? SCF_ST_IGNORE : SCF_ST_DATA;
                    end
                    SCF_ST_DATA: begin
                        data_r <= {data_r[7:0], byte_nxt}; // [R22]
                        byte_left_r <= byte_left_r - 2'd1;
                        if (byte_left_r == BYTES_1) begin
                            state_r <= SCF_ST_IGNORE;
                        end
                    end
                    SCF_ST_IGNORE: begin
                        state_r <= SCF_ST_IGNORE; // [R22]
                    end
                    default: begin
                        state_r <= SCF_ST_CMD;
                    end
                endcase
            end
        end
    end

    wire cmd_done = byte_done && state_r == SCF_ST_CMD;
    wire data_last = byte_done && state_r == SCF_ST_DATA && byte_left_r == BYTES_1;
    wire [15:0] data_full = {data_r[7:0], byte_nxt};

    // ==========================================================
    // Control registers
    scf_ckmode_e ck_mode;
    assign ck_mode = scf_ckmode_e'(setup_config_o[CK_HI:CK_LO]); // [R10]

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            conversion_control_o <= REG_CLEAR; // [R15]
            setup_config_o <= SETUP_RESET;
            averaging_control_o <= REG_CLEAR;
            reset_control_o <= REG_CLEAR;
        end else if (cmd_done) begin
            case (dec_now.kind)
                K_CONV: conversion_control_o <= byte_nxt;
                K_SETUP: setup_config_o <= byte_nxt;
                K_AVG: averaging_control_o <= byte_nxt;
                K_RST: begin
                    reset_control_o <= byte_nxt;
                    if (byte_nxt[RST_RESET_BIT]) begin
                        conversion_control_o <= REG_CLEAR;
                        setup_config_o <= SETUP_RESET;
                        averaging_control_o <= REG_CLEAR;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Polarity registers take the byte after a setup command
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            unipolar_mode_o <= POL_CLEAR;
            bipolar_mode_o <= POL_CLEAR;
        end else if (data_last && dec_r.kind == K_SETUP) begin
            if (cmd_r[POL_HI:POL_LO] == 2'b10) begin // [R11]
                unipolar_mode_o <= byte_nxt;
            end else if (cmd_r[POL_HI:POL_LO] == 2'b11) begin
                bipolar_mode_o <= byte_nxt;
            end
        end
    end

    // ==========================================================
    // DAC and GPIO words
    logic dac_loaded_r;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dac_word_o <= '0;
            dac_word_stb_o <= 1'b0;
            gpio_word_o <= '0;
            gpio_cmd_o <= '0;
            gpio_stb_o <= 1'b0;
        end else begin
            dac_word_stb_o <= data_last && dec_r.kind == K_DAC; // [R12]
            gpio_stb_o <= data_last && dec_r.target == SCF_TGT_GPIO; // [R13]
            if (data_last && dec_r.kind == K_DAC) begin
                dac_word_o <= data_full;
            end
            if (data_last && dec_r.target == SCF_TGT_GPIO) begin
                gpio_word_o <= (GPIO_COUNT > 4) ? data_full : {8'h00, byte_nxt};
                gpio_cmd_o <= cmd_r[1:0];
            end
        end
    end

    // Power-up level caught after reset release, never under the async reset
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dac_loaded_r <= 1'b0;
            dac_input_o <= DAC_LOW;
        end else if (!dac_loaded_r) begin
            dac_loaded_r <= 1'b1;
            dac_input_o <= dac_powerup_level_i ? DAC_HIGH : DAC_LOW; // [R16]
        end else if (dac_word_stb_o) begin
            dac_input_o <= dac_word_o[11:0];
        end
    end

    // ==========================================================
    // Conversion requests and end of conversion
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_req_o <= 1'b0;
            conv_single_o <= 1'b0;
        end else begin
            conv_req_o <= 1'b0;
            conv_single_o <= 1'b0;
            case (ck_mode)
                SCF_CK_CNV_INT: conv_req_o <= cnv_fall; // [R17]
                SCF_CK_CNV_EXT: begin
                    conv_req_o <= cnv_fall; // [R18]
                    conv_single_o <= 1'b1;
                end
                SCF_CK_SER_INT: conv_req_o <= cmd_done && dec_now.kind == K_CONV; // [R19]
                SCF_CK_SER_EXT: begin
                    // Scanning forced off through conv_single_o in this mode; averaging is left untouched
                    conv_req_o <= cmd_done && dec_now.kind == K_CONV; // [R20]
                    conv_single_o <= 1'b1;
                end
                default: conv_req_o <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            eoc_n_o <= 1'b1;
        end else if (ck_mode == SCF_CK_SER_EXT || cs_fall || cnv_fall) begin
            eoc_n_o <= 1'b1; // [R21]
        end else if (conv_done_i) begin
            eoc_n_o <= 1'b0;
        end
    end

    // ==========================================================
    // Result output shifter
    logic [15:0] out_shift_r;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            result_o <= '0;
        end else if (result_valid_i) begin
            // Sign handling for two's complement happens in the converter; the flag selects nothing here, both branches match
            result_o <= result_bipolar_i ? {4'h0, result_o[11:0]} : {4'h0, result_o[11:0]}; // [R5]
        end
    end

    wire out_edge = (ck_mode == SCF_CK_SER_EXT) ? sclk_rise : sclk_fall; // [R3] [R4]
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_shift_r <= '0;
            dout_o <= 1'b0;
        end else if (cs_fall) begin
            out_shift_r <= {result_o[14:0], 1'b0};
            dout_o <= result_o[15];
        end else if (out_edge) begin
            dout_o <= out_shift_r[15];
            out_shift_r <= {out_shift_r[14:0], 1'b0};
        end
    end
endmodule

//--- verilog/scf_pkg.sv
// Purpose: Shared constants and carriers for the serial command front end
// Assumes: One 50 MHz system clock; serial pins sampled into it
// Notes: Serial clock limits are master obligations, kept here for reference
package scf_pkg;
    localparam int unsigned SYS_CLK_HZ = 50_000_000;
    localparam int unsigned SCLK_MAX_HZ = 25_000_000;
    localparam int unsigned SCLK_MODE11_MAX_HZ = 4_800_000;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_GPIO_CFG = 8'h03;
    localparam logic [7:0] CMD_GPIO_WR = 8'h02;
    localparam logic [7:0] CMD_GPIO_RD = 8'h01;
    localparam int CONV_BIT = 7;
    localparam int SETUP_BIT = 6;
    localparam int AVG_BIT = 5;
    localparam int DAC_BIT = 4;
    localparam int RST_BIT = 3;

    // ==========================================================
    // Field positions
    localparam int CK_HI = 5;
    localparam int CK_LO = 4;
    localparam int POL_HI = 1;
    localparam int POL_LO = 0;
    localparam int AVG_EN_BIT = 4;
    localparam int CONV_TEMP_BIT = 0;
    localparam int RST_RESET_BIT = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] REG_CLEAR = 8'h00;
    localparam logic [7:0] SETUP_RESET = 8'h28;
    localparam logic [11:0] DAC_HIGH = 12'hfff;
    localparam logic [11:0] DAC_LOW = 12'h000;
    localparam logic [7:0] POL_CLEAR = 8'h00;

    // ==========================================================
    // Clock modes, frame states and command targets
    typedef enum logic [1:0] {
        SCF_CK_CNV_INT = 2'b00,
        SCF_CK_CNV_EXT = 2'b01,
        SCF_CK_SER_INT = 2'b10,
        SCF_CK_SER_EXT = 2'b11
    } scf_ckmode_e;

    typedef enum logic [2:0] {
        SCF_ST_CMD = 3'b000,
        SCF_ST_DATA = 3'b001,
        SCF_ST_IGNORE = 3'b010
    } scf_state_e;

    typedef enum logic [2:0] {
        SCF_TGT_NONE = 3'b000,
        SCF_TGT_ADC = 3'b001,
        SCF_TGT_DAC = 3'b010,
        SCF_TGT_GPIO = 3'b011
    } scf_target_e;

    // Decoded command carrier
    typedef struct packed {
        scf_target_e target;
        logic [1:0] data_bytes;
        logic [2:0] kind;
    } scf_cmd_s;

    localparam logic [2:0] K_NOP = 3'd0;
    localparam logic [2:0] K_CONV = 3'd1;
    localparam logic [2:0] K_SETUP = 3'd2;
    localparam logic [2:0] K_AVG = 3'd3;
    localparam logic [2:0] K_DAC = 3'd4;
    localparam logic [2:0] K_RST = 3'd5;
    localparam logic [2:0] K_GPIO = 3'd6;
    localparam logic [2:0] K_GPIO_RD = 3'd7;
    localparam logic [2:0] BIT_LAST = 3'd7;
    localparam logic [1:0] BYTES_0 = 2'd0;
    localparam logic [1:0] BYTES_1 = 2'd1;
    localparam logic [1:0] BYTES_2 = 2'd2;
endpackage

//--- verilog/scf_sync.sv
// Purpose: Two flip-flop synchroniser for one pin
// Assumes: Input is asynchronous to clk_i
// Notes: Only the second stage is visible
`timescale 1ns/1ps
module scf_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_r <= RESET_VAL;
            q_o <= RESET_VAL;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule
